// ---- pkg/swra_pkg.sv ----
// Constants and types for the single-wire rise assist sequencer
package swra_pkg;

  // Clock
  localparam int unsigned CLK_PERIOD_NS = 20;

  // Slot timing in ns (plain defaults, standard speed)
  localparam int unsigned RESET_LOW_TIME_NS = 480000;
  localparam int unsigned RESET_HIGH_TIME_NS = 480000;
  localparam int unsigned RISE_ASSIST_DURATION_NS = 20000;
  localparam int unsigned WRITE_ZERO_LOW_TIME_NS = 60000;
  localparam int unsigned WRITE_ONE_LOW_TIME_NS = 6000;
  localparam int unsigned RECOVERY_TIME_NS = 5000;
  localparam int unsigned MASTER_SAMPLE_TIME_NS = 10000;

  // Least times round up to whole cycles
  function automatic int unsigned swra_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : swra_cycles

  localparam int unsigned RESET_LOW_CYC = swra_cycles(RESET_LOW_TIME_NS);
  localparam int unsigned RESET_HIGH_CYC = swra_cycles(RESET_HIGH_TIME_NS);
  localparam int unsigned RISE_ASSIST_DURATION_CYC = swra_cycles(RISE_ASSIST_DURATION_NS);
  localparam int unsigned WRITE_ZERO_LOW_CYC = swra_cycles(WRITE_ZERO_LOW_TIME_NS);
  localparam int unsigned WRITE_ONE_LOW_CYC = swra_cycles(WRITE_ONE_LOW_TIME_NS);
  localparam int unsigned RECOVERY_CYC = swra_cycles(RECOVERY_TIME_NS);
  localparam int unsigned MASTER_SAMPLE_CYC = swra_cycles(MASTER_SAMPLE_TIME_NS);

  // Slot counter width
  localparam int unsigned CNT_WIDTH = 17;

  // Kinds of bus activity
  typedef enum logic [1:0] {
    KIND_RESET = 2'h0,
    KIND_WRITE_ZERO = 2'h1,
    KIND_WRITE_ONE = 2'h2,
    KIND_READ = 2'h3
  } swra_kind_type;

  // Command from the slot sequencer side
  typedef struct packed {
    logic valid;
    swra_kind_type kind;
  } swra_cmd_type;

  // One-hot sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LOW = 6'h02,
    ST_ARMED = 6'h04,
    ST_ASSIST = 6'h08,
    ST_WAIT = 6'h10,
    ST_HOLD = 6'h20
  } swra_state_type;

endpackage : swra_pkg

// ---- hdl/swra_sequencer.sv ----
// Rise assist sequencer for a single-wire bus master
// Operation
// - Assist may act during reset cycles, write slots and read slots.
// - Once armed, assist turns on at upward threshold crossing.
// - Never fire after shorts, presence on power-up, or outside slots.
// - Trigger arms when the initial low phase completes.
// - Reset: low for reset time; assist on for remaining assist duration.
// - Reset: re-arm after assist duration, fire after presence, on to reset end.
// - Write zero: low for zero time, arm, assist until recovery ends.
// - Write one: low for one time, arm, assist until slot end.
// - Read: low for one time, normal pullup on, arm; slave may hold low.
// - Read: sample the line at master sample time from slot start.
// - Read one: assist lasts to slot end, longer than read zero.
// - Strong pullup holds until new command, disable or reset, then self-clears.
// - Strong pullup slot edge handled as if assist active.
// - Strong pullup leaves assist enable setting unchanged.
`timescale 1ns/100ps
`default_nettype none

module swra_sequencer
  import swra_pkg::*;
#(
  parameter int unsigned RESET_LOW = RESET_LOW_CYC,
  parameter int unsigned RESET_HIGH = RESET_HIGH_CYC,
  parameter int unsigned ASSIST_DURATION = RISE_ASSIST_DURATION_CYC,
  parameter int unsigned WRITE_ZERO_LOW = WRITE_ZERO_LOW_CYC,
  parameter int unsigned WRITE_ONE_LOW = WRITE_ONE_LOW_CYC,
  parameter int unsigned RECOVERY = RECOVERY_CYC,
  parameter int unsigned MASTER_SAMPLE = MASTER_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration
  input wire logic rise_assist_enable,
  input wire logic strong_pullup_set,
  input wire logic strong_pullup_clear,
  // Commands from the slot sequencer
  input wire swra_cmd_type cmd,
  // Line sensing
  input wire logic line_high,
  input wire logic rise_assist_threshold,
  // Line drive
  output logic line_pulldown,
  output logic normal_pullup,
  output logic rise_assist,
  // Status
  output logic busy,
  output logic cmd_done,
  output logic read_valid,
  output logic read_bit,
  output logic strong_pullup_enabled
);

  ////////////////////////////////////////////////////////////////////////////
  // Slot window lengths

  localparam logic [CNT_WIDTH-1:0] RST_LOW_END = CNT_WIDTH'(RESET_LOW - 1);
  localparam logic [CNT_WIDTH-1:0] RST_ASSIST_END = CNT_WIDTH'(RESET_LOW + ASSIST_DURATION - 1);
  localparam logic [CNT_WIDTH-1:0] RST_SLOT_END = CNT_WIDTH'(RESET_LOW + RESET_HIGH - 1);
  localparam logic [CNT_WIDTH-1:0] W0_LOW_END = CNT_WIDTH'(WRITE_ZERO_LOW - 1);
  localparam logic [CNT_WIDTH-1:0] W1_LOW_END = CNT_WIDTH'(WRITE_ONE_LOW - 1);
  localparam logic [CNT_WIDTH-1:0] SLOT_END = CNT_WIDTH'(WRITE_ZERO_LOW + RECOVERY - 1);
  localparam logic [CNT_WIDTH-1:0] SAMPLE_AT = CNT_WIDTH'(MASTER_SAMPLE - 1);
  localparam logic [CNT_WIDTH-1:0] CNT_ONE = CNT_WIDTH'(1);

  // Last cycle of the initial low phase for each kind
  function automatic logic [CNT_WIDTH-1:0] low_end(input swra_kind_type k);
    unique case (k)
      KIND_RESET: low_end = RST_LOW_END;
      KIND_WRITE_ZERO: low_end = W0_LOW_END;
      KIND_WRITE_ONE: low_end = W1_LOW_END;
      KIND_READ: low_end = W1_LOW_END;
    endcase
  endfunction : low_end

  // Last cycle of the whole slot or reset cycle
  function automatic logic [CNT_WIDTH-1:0] slot_end(input swra_kind_type k);
    slot_end = (k == KIND_RESET) ? RST_SLOT_END : SLOT_END;
  endfunction : slot_end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchronizer and rising edge

  logic thr_meta;
  logic thr_sync;
  logic thr_prev;
  logic thr_rise;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      thr_meta <= 1'b0;
      thr_sync <= 1'b0;
      thr_prev <= 1'b0;
    end else begin
      thr_meta <= rise_assist_threshold;
      thr_sync <= thr_meta;
      thr_prev <= thr_sync;
    end
  end

  assign thr_rise = thr_sync & ~thr_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  swra_state_type state;
  swra_state_type next_state;
  swra_kind_type kind;
  logic [CNT_WIDTH-1:0] cnt;
  logic second_phase;
  logic strong_slot;
  logic start;
  logic trig_ok;
  logic at_end;

  // A new command is only taken when idle or holding the strong pullup
  assign start = cmd.valid & (state == ST_IDLE || state == ST_HOLD);
  // Strong pullup slot fires even when the assist is disabled
  assign trig_ok = rise_assist_enable | strong_slot;
  assign at_end = (cnt == slot_end(kind));

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (cnt == low_end(kind)) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (at_end) begin
          next_state = strong_slot ? ST_HOLD : ST_IDLE;
        end else if (thr_rise && trig_ok) begin
          next_state = ST_ASSIST;
        end
      end
      ST_ASSIST: begin
        if (at_end) begin
          next_state = strong_slot ? ST_HOLD : ST_IDLE;
        end else if (kind == KIND_RESET && !second_phase && cnt == RST_ASSIST_END) begin
          next_state = ST_ARMED;
        end
      end
      ST_WAIT: begin
        if (at_end) begin
          next_state = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (start) begin
          next_state = ST_LOW;
        end else if (strong_pullup_clear) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Slot timer runs from the falling edge of the slot
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= '0;
    end else if (state != ST_IDLE && state != ST_HOLD) begin
      cnt <= cnt + CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kind <= KIND_RESET;
    end else if (start) begin
      kind <= cmd.kind;
    end
  end

  // Second half of a reset cycle waits for the presence pulse to end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      second_phase <= 1'b0;
    end else if (start) begin
      second_phase <= 1'b0;
    end else if (kind == KIND_RESET && cnt == RST_ASSIST_END) begin
      second_phase <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strong pullup enable

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strong_pullup_enabled <= 1'b0;
    end else if (strong_pullup_clear) begin
      strong_pullup_enabled <= 1'b0;
    end else if (strong_pullup_set) begin
      strong_pullup_enabled <= 1'b1;
    end else if (state == ST_HOLD && start) begin
      strong_pullup_enabled <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strong_slot <= 1'b0;
    end else if (start) begin
      // Clear wins over a command taken in the same cycle
      strong_slot <= strong_pullup_enabled && !strong_pullup_clear && state != ST_HOLD;
    end else if (strong_pullup_clear) begin
      strong_slot <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line drive, all registered from the next state

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_pulldown <= 1'b0;
      normal_pullup <= 1'b1;
      rise_assist <= 1'b0;
      busy <= 1'b0;
    end else begin
      line_pulldown <= (next_state == ST_LOW);
      normal_pullup <= (next_state != ST_LOW);
      // Assist only inside a slot or as the strong pullup hold
      rise_assist <= (next_state == ST_ASSIST) || (next_state == ST_HOLD);
      busy <= (next_state != ST_IDLE) && (next_state != ST_HOLD);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= (state == ST_ARMED || state == ST_ASSIST || state == ST_WAIT) && at_end;
    end
  end

  // Read sample
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      read_valid <= 1'b0;
      read_bit <= 1'b0;
    end else begin
      read_valid <= 1'b0;
      if (kind == KIND_READ && state != ST_IDLE && state != ST_HOLD && cnt == SAMPLE_AT) begin
        read_valid <= 1'b1;
        read_bit <= line_high;
      end
    end
  end

endmodule : swra_sequencer

`default_nettype wire

// ---- test/swra_checker.sv ----
// Assertion checker for the rise assist sequencer
`timescale 1ns/100ps
`default_nettype none
module swra_checker
  import swra_pkg::*;
#(
  parameter int unsigned RESET_LOW = 1,
  parameter int unsigned RESET_HIGH = 1,
  parameter int unsigned WRITE_ZERO_LOW = 1,
  parameter int unsigned WRITE_ONE_LOW = 1,
  parameter int unsigned RECOVERY = 1
) (
  // Clock and inputs
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rise_assist_enable,
  input wire logic strong_pullup_clear,
  input wire swra_cmd_type cmd,
  input wire logic rise_assist_threshold,
  // Outputs
  input wire logic line_pulldown,
  input wire logic rise_assist,
  input wire logic busy,
  input wire logic cmd_done,
  input wire logic strong_pullup_enabled
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  swra_kind_type kind;
  int unsigned pd_cnt;
  int unsigned busy_cnt;
  int unsigned low_len;
  int unsigned slot_len;
  assign low_len = (kind == KIND_RESET) ? RESET_LOW :
                   (kind == KIND_WRITE_ZERO) ? WRITE_ZERO_LOW : WRITE_ONE_LOW;
  assign slot_len = (kind == KIND_RESET) ? RESET_LOW + RESET_HIGH : WRITE_ZERO_LOW + RECOVERY;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kind <= KIND_RESET;
    end else if (cmd.valid && !busy) begin
      kind <= cmd.kind;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pd_cnt <= 0;
      busy_cnt <= 0;
    end else begin
      pd_cnt <= line_pulldown ? pd_cnt + 1 : 0;
      busy_cnt <= busy ? busy_cnt + 1 : 0;
    end
  end
  property p_take; cmd.valid && !busy |=> busy && line_pulldown; endproperty
  a_take: assert property (p_take) else $error("command not taken");
  property p_low_len; $fell(line_pulldown) |-> pd_cnt == low_len; endproperty
  a_low_len: assert property (p_low_len) else $error("low phase length wrong");
  property p_slot_len; $fell(busy) |-> busy_cnt == slot_len; endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot length wrong");
  property p_quiet_low; line_pulldown && $past(line_pulldown) |-> !rise_assist; endproperty
  a_quiet_low: assert property (p_quiet_low) else $error("assist during low phase");
  property p_cause; $rose(rise_assist) |-> $past(rise_assist_threshold); endproperty
  a_cause: assert property (p_cause) else $error("assist without crossing");
  property p_gate;
    $rose(rise_assist) |-> $past(rise_assist_enable) || $past(strong_pullup_enabled);
  endproperty
  a_gate: assert property (p_gate) else $error("assist fired while disabled");
  property p_idle;
    !busy && !$past(busy) && !strong_pullup_enabled && !$past(strong_pullup_enabled)
      |-> !rise_assist;
  endproperty
  a_idle: assert property (p_idle) else $error("assist outside slot");
  property p_done; $fell(busy) |-> cmd_done ##1 !cmd_done; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_clear; strong_pullup_clear && !busy |=> !strong_pullup_enabled; endproperty
  a_clear: assert property (p_clear) else $error("strong pullup not cleared");
  c_reset: cover property ($fell(busy) && kind == KIND_RESET);
  c_read: cover property ($fell(busy) && kind == KIND_READ);
  c_hold: cover property (!busy && rise_assist && strong_pullup_enabled);
endmodule : swra_checker
bind swra_sequencer swra_checker #(.RESET_LOW(RESET_LOW), .RESET_HIGH(RESET_HIGH),
  .WRITE_ZERO_LOW(WRITE_ZERO_LOW), .WRITE_ONE_LOW(WRITE_ONE_LOW), .RECOVERY(RECOVERY))
  i_chk (.ref_clk, .rst, .rise_assist_enable, .strong_pullup_clear, .cmd,
  .rise_assist_threshold, .line_pulldown, .rise_assist, .busy, .cmd_done,
  .strong_pullup_enabled);
`default_nettype wire

// ---- test/swra_line_model.sv ----
// Behavioural model of the slave devices on the single-wire line
`timescale 1ns/100ps
`default_nettype none
module swra_line_model #(
  // Cycles a zero answer keeps the line low after the master lets go
  parameter int unsigned RESPONSE = 12
) (
  // Clock and master drive
  input wire logic ref_clk,
  input wire logic line_pulldown,
  // Scenario control
  input wire logic answer_zero,
  // Line sensing
  output logic line_high,
  output logic rise_assist_threshold
);
  int unsigned low_cnt = 0;
  int unsigned hold = 0;
  int unsigned delay = 0;
  always @(posedge ref_clk) begin
    low_cnt <= line_pulldown ? low_cnt + 1 : 0;
    hold <= (hold > 0) ? hold - 1 : ((delay == 1) ? 30 : 0);
    delay <= (delay > 0) ? delay - 1 : 0;
    if (!line_pulldown && low_cnt >= 50) begin
      delay <= 30; // Presence pulse after a long low
    end else if (!line_pulldown && low_cnt > 0 && answer_zero) begin
      hold <= RESPONSE - 1; // Zero answer keeps the line low
    end
  end
  // Slave joins the low while the master still drives it, so no gap appears
  assign line_high = !(line_pulldown || hold > 0 || (answer_zero && low_cnt > 0));
  assign rise_assist_threshold = line_high;
endmodule : swra_line_model
`default_nettype wire

// ---- test/single_wire_rise_assist_sequencer_tb.sv ----
// Self-checking testbench for the rise assist sequencer
`timescale 1ns/100ps
`default_nettype none
module single_wire_rise_assist_sequencer_tb;
  import swra_pkg::*;
  // Slot timing in cycles; the reset cycle keeps the package low and high times
  localparam int unsigned W0L = 40;
  localparam int unsigned W1L = 5;
  localparam int unsigned REC = 10;
  localparam int unsigned ASSIST = 20;
  localparam int unsigned SAMPLE = 10;
  // Two synchronizer stages and the registered assist output delay the assist
  localparam int SYNC_LAT = 3;
  // Matches the line model's zero answer length
  localparam int SLAVE_RESP = 12;
  // Assist cycles of a write-one or read-one slot
  localparam int ONE_ON = int'(W0L + REC - W1L) - SYNC_LAT;
  logic ref_clk = 0, rst = 1, ena = 0, sp_set = 0, sp_clr = 0, ans0 = 0;
  logic line_high, thr, pd, npu, ra, busy, done, rv, rb, spe;
  swra_cmd_type cmd = '0;
  int failures = 0, tests_run = 0, fires = 0, on_cnt = 0, rv_cnt = 0, lo_cnt = 0;
  always #10 ref_clk = ~ref_clk;
  swra_sequencer #(.ASSIST_DURATION(ASSIST), .WRITE_ZERO_LOW(W0L), .WRITE_ONE_LOW(W1L),
    .RECOVERY(REC), .MASTER_SAMPLE(SAMPLE)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .rise_assist_enable(ena), .strong_pullup_set(sp_set),
    .strong_pullup_clear(sp_clr), .cmd(cmd), .line_high(line_high),
    .rise_assist_threshold(thr), .line_pulldown(pd), .normal_pullup(npu),
    .rise_assist(ra), .busy(busy), .cmd_done(done), .read_valid(rv), .read_bit(rb),
    .strong_pullup_enabled(spe));
  swra_line_model i_line (.ref_clk(ref_clk), .line_pulldown(pd), .answer_zero(ans0),
    .line_high(line_high), .rise_assist_threshold(thr));
  always @(posedge ref_clk) begin
    fires <= cmd.valid ? 0 : fires + int'($rose(ra));
    on_cnt <= cmd.valid ? 0 : on_cnt + int'(ra && busy);
    rv_cnt <= cmd.valid ? 0 : rv_cnt + int'(rv);
    lo_cnt <= cmd.valid ? 0 : lo_cnt + int'(pd && !npu);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic send(input swra_kind_type k);
    @(negedge ref_clk) cmd = '{1'b1, k};
    @(negedge ref_clk) cmd.valid = 1'b0;
    repeat (50000) begin
      if (done) break;
      @(negedge ref_clk);
    end
    check(32'(done), 32'd1);
  endtask : send
  task automatic t_reset();
    ena = 1'b1;
    send(KIND_RESET);
    check(fires, 2);
    check(lo_cnt, RESET_LOW_CYC);
  endtask : t_reset
  task automatic t_writes();
    send(KIND_WRITE_ZERO);
    check(fires, 1);
    check(on_cnt, int'(REC) - SYNC_LAT);
    check(lo_cnt, W0L);
    send(KIND_WRITE_ONE);
    check(on_cnt, ONE_ON);
    check(lo_cnt, W1L);
  endtask : t_writes
  task automatic t_reads();
    ans0 = 1'b1;
    send(KIND_READ);
    check(32'(rb), 32'd0);
    check(on_cnt, ONE_ON - SLAVE_RESP);
    check(rv_cnt, 1);
    check(lo_cnt, W1L);
    ans0 = 1'b0;
    send(KIND_READ);
    check(32'(rb), 32'd1);
    check(on_cnt, ONE_ON);
  endtask : t_reads
  task automatic t_disabled();
    ena = 1'b0;
    send(KIND_WRITE_ONE);
    check(fires, 0);
    check(on_cnt, 0);
    check(rv_cnt, 0);
  endtask : t_disabled
  task automatic t_strong();
    @(negedge ref_clk) sp_set = 1'b1;
    @(negedge ref_clk) sp_set = 1'b0;
    send(KIND_WRITE_ONE);
    check(fires, 1);
    check(on_cnt, ONE_ON);
    repeat (5) @(negedge ref_clk);
    check({30'd0, ra, spe}, 32'h3);
    send(KIND_WRITE_ZERO);
    check(fires, 0);
    check({30'd0, spe, ra}, 32'h0);
    @(negedge ref_clk) sp_set = 1'b1;
    @(negedge ref_clk) sp_set = 1'b0;
    send(KIND_WRITE_ONE);
    @(negedge ref_clk) sp_clr = 1'b1;
    @(negedge ref_clk) sp_clr = 1'b0;
    check({30'd0, ra, spe}, 32'h0);
    sp_set = 1'b1;
    @(negedge ref_clk) sp_set = 1'b0;
    send(KIND_WRITE_ONE);
    rst = 1'b1;
    @(negedge ref_clk) rst = 1'b0;
    check({30'd0, ra, spe}, 32'h0);
    // Assist setting still acts as before once the strong pullup is gone
    ena = 1'b1;
    send(KIND_WRITE_ONE);
    check(fires, 1);
    check({30'd0, ra, spe}, 32'h0);
  endtask : t_strong
  task automatic conclude();
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    // About 49000 cycles of tests, mostly the full-length reset cycle
    #1200000;
    failures++;
    conclude();
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_writes();
    t_reads();
    t_disabled();
    t_strong();
    conclude();
  end
endmodule : single_wire_rise_assist_sequencer_tb
`default_nettype wire
